// ---- hw/emm_pkg.sv ----
// Shared constants and types for the external RAM model.
// Assumes APB byte addresses with one register per aligned 32-bit word.
package emm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map (byte offsets)
  localparam int         APB_AW       = 8;
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_ADDR_LO  = 8'h08;
  localparam logic [7:0] REG_ADDR_HI  = 8'h0c;
  localparam logic [7:0] REG_SEL      = 8'h10;
  localparam logic [7:0] REG_DATA     = 8'h14;
  localparam logic [7:0] REG_INC      = 8'h18;
  localparam logic [7:0] REG_RDATA    = 8'h1c;
  localparam logic [7:0] REG_CALLS    = 8'h20;
  localparam logic [7:0] REG_XFERS    = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout
  localparam int         OP_LSB       = 0;
  localparam int         OP_MSB       = 1;
  localparam int         BUSY_BIT     = 0;
  localparam logic [1:0] OP_READ      = 2'h1;
  localparam logic [1:0] OP_WRITE     = 2'h2;
  localparam logic [1:0] OP_FILL      = 2'h3;
  localparam logic [31:0] WORD_ZERO   = 32'h0;
  localparam logic [31:0] WORD_ONE    = 32'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_FILL} emm_state_type;

  // Raw pin controls, polarity as wired
  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic oe;
    logic bt;
    logic rst;
  } emm_ctl_type;

endpackage : emm_pkg

// ---- hw/emm_delay.sv ----
// Read-latency delay line: DEPTH register stages with synchronous clear.
// Assumes one clock; DEPTH of zero passes the input straight through.
`timescale 1ns/100ps
`default_nettype none
module emm_delay #(
  parameter int W     = 1,
  parameter int DEPTH = 0
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         clr_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  if (DEPTH < 0 || W < 1) begin : g_bad
    $error("emm_delay: illegal parameters");
  end

  if (DEPTH == 0) begin : g_pass
    assign q_o = d_i;
  end else begin : g_pipe
    logic [W-1:0] stage_reg [DEPTH];
    for (genvar i = 0; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          stage_reg[i] <= '0;
        end else if (clr_i) begin
          stage_reg[i] <= '0;
        end else begin
          stage_reg[i] <= (i == 0) ? d_i : stage_reg[(i == 0) ? 0 : i - 1];
        end
      end
    end
    assign q_o = stage_reg[DEPTH-1];
  end

endmodule : emm_delay
`default_nettype wire

// ---- hw/emm_mem.sv ----
// Storage array of the RAM model: one masked write port, two async reads.
// Assumes the caller resolves write-port contention before we_i.
`timescale 1ns/100ps
`default_nettype none
module emm_mem #(
  parameter int DATA_W   = 32,
  parameter int NSYM     = 4,
  parameter int AW       = 8,
  parameter int INIT_LEN = 0,
  parameter logic [((INIT_LEN > 0) ? INIT_LEN : 1)*DATA_W-1:0] INIT_IMAGE = '0
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              we_i,
  input  wire logic [AW-1:0]     waddr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [NSYM-1:0]   wsym_i,
  input  wire logic [AW-1:0]     raddr_a_i,
  output logic      [DATA_W-1:0] q_a_o,
  input  wire logic [AW-1:0]     raddr_b_i,
  output logic      [DATA_W-1:0] q_b_o
);

  localparam int SYM_W = DATA_W / NSYM;

  if (INIT_LEN < 0 || INIT_LEN > (2 ** AW)) begin : g_bad
    $error("emm_mem: image larger than array");
  end

  logic [DATA_W-1:0] mem_array [2 ** AW];
  logic [DATA_W-1:0] wbits;
  logic [DATA_W-1:0] old_word;

  // One image only, entry i lands at location i; no image leaves X
  initial begin
    for (int i = 0; i < INIT_LEN; i++) begin
      mem_array[i] = INIT_IMAGE[i*DATA_W +: DATA_W];
    end
  end

  // Plain always: the array is also preloaded by the initial block
  always @(posedge clk_i) begin
    if (we_i) begin
      for (int s = 0; s < NSYM; s++) begin
        if (wsym_i[s]) begin
          mem_array[waddr_i][s*SYM_W +: SYM_W] <= wdata_i[s*SYM_W +: SYM_W];
        end
      end
    end
  end

  assign q_a_o    = mem_array[raddr_a_i];
  assign q_b_o    = mem_array[raddr_b_i];
  assign old_word = mem_array[waddr_i];

  for (genvar s = 0; s < NSYM; s++) begin : g_bits
    assign wbits[s*SYM_W +: SYM_W] = {SYM_W{wsym_i[s]}};
  end

  chk_write_merge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    we_i |=> mem_array[$past(waddr_i)] ===
             (($past(wdata_i) & $past(wbits)) | ($past(old_word) & ~$past(wbits))))
    else $error("masked write did not merge symbols");

endmodule : emm_mem
`default_nettype wire

// ---- hw/emm_top.sv ----
// External RAM model on a shared tri-state data conduit, with an APB
// window for backdoor fill, read and write of the contents.
// Assumes pins synchronous to clk_i and a tri-state controller far end.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module emm_top #(
  parameter int ADDR_W    = 8,
  parameter int SYM_W     = 8,
  parameter int NSYM      = 4,
  parameter int RD_LAT    = 0,
  parameter int MEM_DEPTH = 256,
  parameter bit USE_BE    = 1'b1,
  parameter bit USE_CS    = 1'b1,
  parameter bit USE_RST   = 1'b0,
  parameter bit INV_BE    = 1'b0,
  parameter bit INV_CS    = 1'b0,
  parameter bit INV_WR    = 1'b0,
  parameter bit INV_RD    = 1'b0,
  parameter bit INV_OE    = 1'b0,
  parameter bit INV_BT    = 1'b0,
  parameter bit INV_RST   = 1'b0,
  parameter int INIT_LEN  = 0,
  parameter logic [((INIT_LEN > 0) ? INIT_LEN : 1)*SYM_W*NSYM-1:0] INIT_IMAGE = '0
) (
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [emm_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic [ADDR_W-1:0]         addr_i,
  input  wire logic [SYM_W*NSYM-1:0]     data_in_i,
  output logic      [SYM_W*NSYM-1:0]     data_out_o,
  output logic      [NSYM-1:0]           data_oe_o,
  input  wire logic [NSYM-1:0]           be_i,
  input  wire emm_pkg::emm_ctl_type      ctl_i,
  output logic                           api_call_o
);

  localparam int DATA_W = SYM_W * NSYM;
  localparam int MEM_AW = $clog2(MEM_DEPTH);
  localparam int NSL    = (DATA_W + 31) / 32;
  localparam int SEL_W  = (NSL > 1) ? $clog2(NSL) : 1;
  localparam int PAD_W  = NSL * 32;
  localparam int LAT0   = RD_LAT;
  localparam int LAT1   = RD_LAT + 1;

  if (ADDR_W < 1 || ADDR_W > 32 || SYM_W < 1 || SYM_W > 1024 ||
      NSYM < 1 || NSYM > 128 || (NSYM & (NSYM - 1)) != 0 || RD_LAT < 0 ||
      MEM_DEPTH < 2 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0 ||
      MEM_AW > ADDR_W) begin : g_bad
    $error("emm_top: illegal parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic act_lvl(input logic v, input bit inv);
    return v ^ inv;
  endfunction : act_lvl

  function automatic logic [31:0] get_slice(input logic [PAD_W-1:0] v,
                                            input logic [SEL_W-1:0] s);
    return v[s*32 +: 32];
  endfunction : get_slice

  function automatic logic [PAD_W-1:0] put_slice(input logic [PAD_W-1:0] v,
                                                 input logic [SEL_W-1:0] s,
                                                 input logic [31:0]      w);
    logic [PAD_W-1:0] r;
    r = v;
    r[s*32 +: 32] = w;
    return r;
  endfunction : put_slice

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode

  logic            cs_act, wr_act, rd_act, oe_act, bt_act, rst_act;
  logic            pin_we, pin_rd;
  logic [NSYM-1:0] be_act;

  always_comb begin
    cs_act  = USE_CS ? act_lvl(ctl_i.cs, INV_CS) : 1'b1;
    rst_act = USE_RST ? act_lvl(ctl_i.rst, INV_RST) : 1'b0;
    wr_act  = act_lvl(ctl_i.wr, INV_WR);
    rd_act  = act_lvl(ctl_i.rd, INV_RD);
    oe_act  = act_lvl(ctl_i.oe, INV_OE);
    bt_act  = act_lvl(ctl_i.bt, INV_BT);
    be_act  = USE_BE ? (be_i ^ {NSYM{INV_BE}}) : '1;
    pin_we  = cs_act && wr_act && !rst_act;
    pin_rd  = cs_act && rd_act && oe_act && !wr_act && !rst_act;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one access cycle, pready from a flop

  logic                  pready_reg, pslverr_reg, api_call_reg;
  logic [31:0]           prdata_reg, rd_word, calls_reg, xfers_reg;
  logic                  apb_setup, apb_wr, cmd_go;
  logic [ADDR_W-1:0]     addr_lo_reg, addr_hi_reg, fill_addr_reg;
  logic [SEL_W-1:0]      sel_reg;
  logic [PAD_W-1:0]      data_reg, inc_reg, rdata_reg;
  logic [DATA_W-1:0]     fill_data_reg;
  emm_pkg::emm_state_type st_reg;

  assign apb_setup = psel_i && !penable_i;
  assign apb_wr    = psel_i && penable_i && pready_reg && pwrite_i;
  assign cmd_go    = apb_wr && (paddr_i == emm_pkg::REG_CMD);

  function automatic logic is_mapped(input logic [emm_pkg::APB_AW-1:0] a);
    return a inside {emm_pkg::REG_CMD, emm_pkg::REG_STATUS, emm_pkg::REG_ADDR_LO,
                     emm_pkg::REG_ADDR_HI, emm_pkg::REG_SEL, emm_pkg::REG_DATA,
                     emm_pkg::REG_INC, emm_pkg::REG_RDATA, emm_pkg::REG_CALLS,
                     emm_pkg::REG_XFERS};
  endfunction : is_mapped

  always_comb begin
    rd_word = emm_pkg::WORD_ZERO;
    unique case (paddr_i)
      emm_pkg::REG_STATUS:  rd_word[emm_pkg::BUSY_BIT] = (st_reg != emm_pkg::ST_IDLE);
      emm_pkg::REG_ADDR_LO: rd_word = 32'(addr_lo_reg);
      emm_pkg::REG_ADDR_HI: rd_word = 32'(addr_hi_reg);
      emm_pkg::REG_SEL:     rd_word = 32'(sel_reg);
      emm_pkg::REG_DATA:    rd_word = get_slice(data_reg, sel_reg);
      emm_pkg::REG_INC:     rd_word = get_slice(inc_reg, sel_reg);
      emm_pkg::REG_RDATA:   rd_word = get_slice(rdata_reg, sel_reg);
      emm_pkg::REG_CALLS:   rd_word = calls_reg;
      emm_pkg::REG_XFERS:   rd_word = xfers_reg;
      default:              rd_word = emm_pkg::WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= emm_pkg::WORD_ZERO;
    end else begin
      pready_reg <= apb_setup;
      if (apb_setup) begin
        pslverr_reg <= !is_mapped(paddr_i);
        prdata_reg  <= rd_word;
      end
    end
  end

  // Operand registers; DATA and INC are reached one 32-bit slice at a time
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_lo_reg <= '0;
      addr_hi_reg <= '0;
      sel_reg     <= '0;
      data_reg    <= '0;
      inc_reg     <= '0;
    end else if (apb_wr) begin
      unique case (paddr_i)
        emm_pkg::REG_ADDR_LO: addr_lo_reg <= pwdata_i[ADDR_W-1:0];
        emm_pkg::REG_ADDR_HI: addr_hi_reg <= pwdata_i[ADDR_W-1:0];
        emm_pkg::REG_SEL:     if (pwdata_i < 32'(NSL)) sel_reg <= pwdata_i[SEL_W-1:0];
        emm_pkg::REG_DATA:    data_reg <= put_slice(data_reg, sel_reg, pwdata_i);
        emm_pkg::REG_INC:     inc_reg <= put_slice(inc_reg, sel_reg, pwdata_i);
        default:              ;
      endcase
    end
  end

  // Every call is announced, even one refused while busy
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      api_call_reg <= 1'b0;
      calls_reg    <= emm_pkg::WORD_ZERO;
    end else begin
      api_call_reg <= cmd_go;
      if (cmd_go) begin
        calls_reg <= calls_reg + emm_pkg::WORD_ONE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xfers_reg <= emm_pkg::WORD_ZERO;
    end else if (bt_act && cs_act && !rst_act) begin
      xfers_reg <= xfers_reg + emm_pkg::WORD_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Backdoor engine; pin writes win the shared write port

  logic                  eng_we, mem_we;
  logic [MEM_AW-1:0]     mem_waddr;
  logic [DATA_W-1:0]     mem_wdata, q_a, q_b;
  logic [NSYM-1:0]       mem_wsym;

  always_comb begin
    eng_we = ((st_reg == emm_pkg::ST_WRITE) || (st_reg == emm_pkg::ST_FILL)) && !pin_we;
    mem_we = pin_we || eng_we;
    if (pin_we) begin
      mem_waddr = addr_i[MEM_AW-1:0];
      mem_wdata = data_in_i;
      mem_wsym  = be_act;
    end else if (st_reg == emm_pkg::ST_FILL) begin
      mem_waddr = fill_addr_reg[MEM_AW-1:0];
      mem_wdata = fill_data_reg;
      mem_wsym  = '1;
    end else begin
      mem_waddr = addr_lo_reg[MEM_AW-1:0];
      mem_wdata = data_reg[DATA_W-1:0];
      mem_wsym  = '1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg        <= emm_pkg::ST_IDLE;
      fill_addr_reg <= '0;
      fill_data_reg <= '0;
      rdata_reg     <= '0;
    end else begin
      unique case (st_reg)
        emm_pkg::ST_IDLE: begin
          if (cmd_go) begin
            unique case (pwdata_i[emm_pkg::OP_MSB:emm_pkg::OP_LSB])
              emm_pkg::OP_READ:  st_reg <= emm_pkg::ST_READ;
              emm_pkg::OP_WRITE: st_reg <= emm_pkg::ST_WRITE;
              emm_pkg::OP_FILL: begin
                // Empty range writes nothing
                if (addr_lo_reg <= addr_hi_reg) begin
                  st_reg <= emm_pkg::ST_FILL;
                end
                fill_addr_reg <= addr_lo_reg;
                fill_data_reg <= data_reg[DATA_W-1:0];
              end
              default: ;
            endcase
          end
        end
        emm_pkg::ST_READ: begin
          rdata_reg <= PAD_W'(q_b);
          st_reg    <= emm_pkg::ST_IDLE;
        end
        emm_pkg::ST_WRITE: begin
          if (eng_we) begin
            st_reg <= emm_pkg::ST_IDLE;
          end
        end
        emm_pkg::ST_FILL: begin
          if (eng_we) begin
            if (fill_addr_reg == addr_hi_reg) begin
              st_reg <= emm_pkg::ST_IDLE;
            end else begin
              fill_addr_reg <= ADDR_W'(fill_addr_reg + 1'b1);
              fill_data_reg <= fill_data_reg + inc_reg[DATA_W-1:0];
            end
          end
        end
      endcase
    end
  end

  emm_mem #(
    .DATA_W     (DATA_W),
    .NSYM       (NSYM),
    .AW         (MEM_AW),
    .INIT_LEN   (INIT_LEN),
    .INIT_IMAGE (INIT_IMAGE)
  ) u_mem (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (mem_wdata),
    .wsym_i    (mem_wsym),
    .raddr_a_i (addr_i[MEM_AW-1:0]),
    .q_a_o     (q_a),
    .raddr_b_i (addr_lo_reg[MEM_AW-1:0]),
    .q_b_o     (q_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path: captured at the sampling edge, then RD_LAT more stages

  logic [NSYM-1:0]   oe0_reg;
  logic [DATA_W-1:0] dout0_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe0_reg   <= '0;
      dout0_reg <= '0;
    end else if (rst_act) begin
      oe0_reg   <= '0;
      dout0_reg <= '0;
    end else begin
      oe0_reg <= pin_rd ? be_act : '0;
      if (pin_rd) begin
        dout0_reg <= q_a;
      end
    end
  end

  emm_delay #(
    .W     (NSYM + DATA_W),
    .DEPTH (RD_LAT)
  ) u_lat (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .clr_i    (rst_act),
    .d_i      ({oe0_reg, dout0_reg}),
    .q_o      ({data_oe_o, data_out_o})
  );

  assign prdata_o   = prdata_reg;
  assign pready_o   = pready_reg;
  assign pslverr_o  = pslverr_reg;
  assign api_call_o = api_call_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] rst_age_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_age_reg <= '0;
    end else if (rst_act) begin
      rst_age_reg <= '0;
    end else if (rst_age_reg != 8'hff) begin
      rst_age_reg <= rst_age_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_read_data: assert property (
    pin_rd |-> ##LAT1 (data_out_o === $past(q_a, LAT1) || rst_age_reg <= 8'(LAT1)))
    else $error("read word not presented after latency");
  chk_read_lanes: assert property (
    pin_rd |-> ##LAT1 (data_oe_o == $past(be_act, LAT1) || rst_age_reg <= 8'(LAT1)))
    else $error("drive lanes differ from byte enables");
  chk_release_pins: assert property (
    !pin_rd |-> ##LAT1 (data_oe_o == '0))
    else $error("pins driven without qualified read");
  chk_select_gate: assert property (
    !cs_act |=> (xfers_reg == $past(xfers_reg)) ##LAT0 (data_oe_o == '0))
    else $error("activity without device select");
  chk_pin_write: assert property (
    (wr_act && cs_act && !rst_act) |-> mem_we && mem_waddr == addr_i[MEM_AW-1:0]
                                       && mem_wdata == data_in_i)
    else $error("selected write not applied");
  chk_fill_step: assert property (
    (st_reg == emm_pkg::ST_FILL && eng_we && fill_addr_reg != addr_hi_reg) |=>
      fill_addr_reg == $past(fill_addr_reg) + 1'b1 &&
      fill_data_reg == $past(fill_data_reg) + $past(inc_reg[DATA_W-1:0]))
    else $error("fill did not advance");
  chk_fill_stop: assert property (
    (st_reg == emm_pkg::ST_FILL && eng_we && fill_addr_reg == addr_hi_reg) |=>
      st_reg == emm_pkg::ST_IDLE)
    else $error("fill ran past high location");
  chk_bd_read: assert property (
    (cmd_go && st_reg == emm_pkg::ST_IDLE && pwdata_i[1:0] == emm_pkg::OP_READ) |->
      ##2 (rdata_reg[DATA_W-1:0] === $past(q_b) && st_reg == emm_pkg::ST_IDLE))
    else $error("backdoor read wrong");
  chk_bd_write: assert property (
    (st_reg == emm_pkg::ST_WRITE && !pin_we) |-> mem_we &&
      mem_wdata == data_reg[DATA_W-1:0] ##1 st_reg == emm_pkg::ST_IDLE)
    else $error("backdoor write not done");
  chk_api_event: assert property (
    cmd_go |=> api_call_o && calls_reg == $past(calls_reg) + emm_pkg::WORD_ONE)
    else $error("call event missing");
  chk_pin_reset: assert property (
    rst_act |-> (!mem_we || eng_we) ##1 (data_oe_o == '0))
    else $error("pin reset did not idle interface");

endmodule : emm_top
`default_nettype wire

// ---- testbench/emm_far_end.sv ----
// Far-end model: tri-state controller driving the RAM model's pin side.
// Assumes 32-bit data in four lanes, 8-bit location, active-high controls.
`timescale 1ns/100ps
`default_nettype none
module emm_far_end (
  input  wire logic           clk_i,
  input  wire logic [31:0]    dout_i,
  input  wire logic [3:0]     doe_i,
  output logic      [7:0]     addr_o,
  output logic      [31:0]    wire_o,
  output logic      [3:0]     be_o,
  output emm_pkg::emm_ctl_type ctl_o
);
  logic [31:0] drv_reg = '0;
  logic [31:0] last_reg = '0;
  logic        drv_en_reg = 1'b0;
  initial begin
    ctl_o = '0;
    addr_o = '0;
    be_o = '0;
  end
  // Released lanes toggle each cycle so a stale value never passes
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      wire_o[s*8+:8] = doe_i[s] ? dout_i[s*8+:8] :
                       drv_en_reg ? drv_reg[s*8+:8] : ~last_reg[s*8+:8];
    end
  end
  always @(posedge clk_i) last_reg <= wire_o;
  task automatic op(input logic [5:0] c, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d, output logic [31:0] q, output logic [3:0] oe);
    @(posedge clk_i);
    ctl_o <= c;
    addr_o <= a;
    be_o <= be;
    drv_reg <= d;
    drv_en_reg <= c[4];
    @(posedge clk_i);
    ctl_o <= '0;
    drv_en_reg <= 1'b0;
    @(negedge clk_i);
    q = wire_o;
    oe = doe_i;
  endtask : op
endmodule : emm_far_end
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Bench for the external RAM model: APB backdoor plus random pin traffic.
// Assumes default widths and polarities; far end is emm_far_end.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [127:0] IMG = {32'hd4c3b2a1, 32'h0f1e2d3c, 32'h5a6b7c8d, 32'h13572468};
  logic                 clk_i = 1'b0;
  logic                 arst_n_i = 1'b0;
  logic                 psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]           paddr_i = '0, addr_i;
  logic [31:0]          pwdata_i = '0, prdata_o, data_in_i, data_out_o;
  logic                 pready_o, pslverr_o, api_call_o;
  logic [3:0]           data_oe_o, be_i;
  emm_pkg::emm_ctl_type ctl_i;
  logic [31:0]          mem_m [256];
  int                   seed = 49516, err_total = 0, checked = 0, n_cmd = 0, n_pulse = 0;
  emm_top #(.INIT_LEN(4), .INIT_IMAGE(IMG)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .addr_i(addr_i), .data_in_i(data_in_i), .data_out_o(data_out_o), .data_oe_o(data_oe_o),
    .be_i(be_i), .ctl_i(ctl_i), .api_call_o(api_call_o));
  emm_far_end far (.clk_i(clk_i), .dout_i(data_out_o), .doe_i(data_oe_o), .addr_o(addr_i),
    .wire_o(data_in_i), .be_o(be_i), .ctl_o(ctl_i));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (api_call_o === 1'b1) n_pulse++;
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int s = 0; s < 4; s++) if (be[s]) o[s*8+:8] = n[s*8+:8];
    return o;
  endfunction : lanes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // Busy poll is bounded; a stuck op then shows as a data mismatch
  task automatic bd(input logic [1:0] op, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    logic e;
    apb(1'b1, emm_pkg::REG_ADDR_LO, {24'h0, a}, q, e);
    apb(1'b1, emm_pkg::REG_DATA, d, q, e);
    apb(1'b1, emm_pkg::REG_CMD, {30'h0, op}, q, e);
    n_cmd++;
    do begin
      apb(1'b0, emm_pkg::REG_STATUS, 32'h0, q, e);
      n++;
    end while (q[emm_pkg::BUSY_BIT] === 1'b1 && n < 40);
    apb(1'b0, emm_pkg::REG_RDATA, 32'h0, q, e);
  endtask : bd
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q, d;
    logic [3:0] oe, be;
    logic [5:0] c;
    logic [7:0] a;
    logic e;
    logic [5:0] corner [4] = '{6'b110010, 6'b111100, 6'b010010, 6'b101000};
    for (int i = 0; i < 4; i++) mem_m[i] = IMG[i*32+:32];
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    chk({28'h0, data_oe_o}, 32'h0, "oe in reset");
    for (int i = 0; i < 4; i++) begin
      bd(emm_pkg::OP_READ, 8'(i), 32'h0, q);
      chk(q, IMG[i*32+:32], "preload");
    end
    $display("test preload done");
    for (int i = 0; i < 40; i++) begin
      c = (i < 4) ? corner[i] : 6'($random(seed));
      a = 8'($random(seed) & 15);
      be = 4'($random(seed));
      d = $random(seed);
      far.op(c, a, be, d, q, oe);
      chk({28'h0, oe}, (c[5] & c[3] & c[2] & !c[4]) ? {28'h0, be} : 32'h0, "oe");
      if (c[5] & c[3] & c[2] & !c[4]) chk(lanes(0, q, be), lanes(0, mem_m[a], be), "rd");
      if (c[5] & c[4]) mem_m[a] = lanes(mem_m[a], d, be);
      if (i % 4 == 3) bd(emm_pkg::OP_READ, a, 32'h0, q);
      else far.op(6'b101100, a, 4'hf, 32'h0, q, oe);
      chk(q, mem_m[a], "readback");
    end
    $display("test pin traffic done");
    d = $random(seed);
    bd(emm_pkg::OP_WRITE, 8'h20, d, q);
    far.op(6'b101100, 8'h20, 4'hf, 32'h0, q, oe);
    chk(q, d, "backdoor write");
    apb(1'b1, emm_pkg::REG_ADDR_HI, 32'h4c, q, e);
    apb(1'b1, emm_pkg::REG_INC, 32'h2, q, e);
    bd(emm_pkg::OP_FILL, 8'h4a, 32'h1, q);
    for (int k = 8'h49; k < 8'h4e; k++) begin
      if (k >= 8'h4a && k <= 8'h4c) mem_m[k] = 32'h1 + 32'h2 * 32'(k - 8'h4a);
      far.op(6'b101100, 8'(k), 4'hf, 32'h0, q, oe);
      chk(q, mem_m[k], "fill");
    end
    $display("test backdoor done");
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(q, 32'h0, "unmapped data");
    apb(1'b0, emm_pkg::REG_CALLS, 32'h0, q, e);
    chk(q, 32'(n_cmd), "call count");
    chk(32'(n_pulse), 32'(n_cmd), "call pulses");
    $display("test calls done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
